// >>> dv/ctt_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ctt_properties #(
    parameter int PULSE_CYCLES = 8
) (
    // Clock, reset and APB
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Pins and charger controls
    input wire logic charge_enable_pin_n_i,
    input wire logic [6:0] thermistor_sense_input_i,
    input wire logic charge_on_o,
    input wire logic boost_on_o,
    input wire logic host_interrupt_n_o,
    input wire logic host_interrupt_n_oe_o
);
    logic [15:0] low_q; // Cycles the interrupt line has been low
    logic [3:0] pin_q, out_q, cold_q; // Saturating hold counters
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Pulse length counter
    always_ff @(posedge sys_clk_i) begin
        low_q <= (rst_i || host_interrupt_n_o) ? 16'h0000 : low_q + 16'h0001;
    end
    // Hold counters leave room for the input synchronisers
    always_ff @(posedge sys_clk_i) begin
        pin_q <= (rst_i || !charge_enable_pin_n_i) ? 4'h0 : pin_q + {3'h0, pin_q != 4'hF};
    end
    // Thermistor outside the cold-to-hot window
    always_ff @(posedge sys_clk_i) begin
        out_q <= (rst_i || !(thermistor_sense_input_i[0] || !thermistor_sense_input_i[3])) ? 4'h0
            : out_q + {3'h0, out_q != 4'hF};
    end
    // Boost cold comparator held
    always_ff @(posedge sys_clk_i) begin
        cold_q <= (rst_i || !thermistor_sense_input_i[6]) ? 4'h0 : cold_q + {3'h0, cold_q != 4'hF};
    end
    a_pready_access: assert property (pready_o |-> psel_i && penable_i) else $error("pready outside access");
    a_pready_answer: assert property (psel_i && !penable_i |=> pready_o) else $error("no wait-free answer");
    a_unmapped_err: assert property (pready_o && paddr_i > 8'h0C |-> pslverr_o) else $error("no slave error");
    a_unmapped_zero: assert property (pready_o && !pwrite_i && paddr_i > 8'h0C |-> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_int_width: assert property ($rose(host_interrupt_n_o) |-> low_q >= PULSE_CYCLES) else $error("short pulse");
    a_int_max: assert property (low_q <= PULSE_CYCLES + 1) else $error("long pulse");
    a_int_drive: assert property (host_interrupt_n_oe_o == !host_interrupt_n_o) else $error("enable mismatch");
    a_pin_stop: assert property (pin_q >= 4'h8 |-> !charge_on_o) else $error("charging while disabled");
    a_window_stop: assert property (out_q >= 4'h8 |-> !charge_on_o) else $error("charging out of window");
    a_boost_cold: assert property (cold_q >= 4'h8 |-> !boost_on_o) else $error("boost while cold");
    c_pulse: cover property ($fell(host_interrupt_n_o));
    c_boost_stop: cover property ($fell(boost_on_o));
    c_slverr: cover property (pready_o && pslverr_o);
endmodule
bind ctt_top ctt_properties #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .charge_enable_pin_n_i(charge_enable_pin_n_i),
    .thermistor_sense_input_i(thermistor_sense_input_i), .charge_on_o(charge_on_o), .boost_on_o(boost_on_o),
    .host_interrupt_n_o(host_interrupt_n_o), .host_interrupt_n_oe_o(host_interrupt_n_oe_o));
`default_nettype wire

// >>> dv/ctt_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ctt_top_tb;
    import ctt_pkg::*;
    localparam logic [6:0] TSV [3] = '{7'h2C, 7'h3E, 7'h08}; // Normal, cool, warm
    logic clk, rst, psel, pen, pwr, pready, serr, pin_n, rechg, below, low_ok, iin, vin, treg, smin, boost;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, jt;
    logic [6:0] ts;
    logic chg, bon, cap, int_n;
    logic [1:0] scale;
    int err_total, check_count, irq_n, n0;
    ctt_top #(.TICK_CYCLES(4), .PULSE_CYCLES(8)) uut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(serr), .charge_enable_pin_n_i(pin_n), .vbat_above_rechg_i(rechg),
        .ichg_below_term_i(below), .vbat_above_low_i(low_ok), .iin_reg_i(iin), .vin_reg_i(vin),
        .therm_reg_i(treg), .sys_min_reg_i(smin), .boost_req_i(boost), .thermistor_sense_input_i(ts),
        .charge_on_o(chg), .boost_on_o(bon), .cur_scale_o(scale), .volt_cap_4v1_o(cap),
        .host_interrupt_n_o(int_n), .host_interrupt_n_oe_o());
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Count interrupt pulses
    always @(negedge int_n) irq_n++;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) err_total++;
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask
    // New charge cycle by toggling the enable pin
    task automatic restart();
        pin_n <= 1'b1;
        tick(12);
        pin_n <= 1'b0;
        tick(12);
    endtask
    // Expected {voltage cap, current scale} for a range
    function automatic logic [2:0] derate(input logic [31:0] j, input int rng);
        if (rng == 1) return {j[JT_VSET_L], j[JT_ISET_LEN] ? (j[JT_ISET_L] ? 2'h1 : 2'h2) : 2'h0};
        if (rng == 2) return {~j[JT_VSET_H], j[JT_ISET_H +: 2]};
        return 3'h3;
    endfunction
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog well beyond the longest timer run
    initial begin
        tick(60000);
        err_total++;
        print_verdict();
    end
    initial begin
        void'($urandom(3081));
        {psel, pen, pwr, paddr, pwdata, rechg, below, low_ok, iin, vin, treg, smin, boost, pin_n} = '0;
        ts = TSV[0];
        rst = 1'b1;
        tick(5);
        rst <= 1'b0;
        chk("int_n", 32'h1, int_n);
        rdchk("ctrl", CTT_CTRL_OFS, 32'h7DF, CTL_RESET);
        rdchk("jeita", CTT_JEITA_OFS, 32'h3FF, JT_RESET);
        apb(1'b0, 8'h10, 32'h0);
        chk("slverr", 32'h1, serr);
        // Derating per range, zero word first, then random words
        for (int i = 0; i < 6; i++) begin
            jt = (i == 0) ? 32'h0 : $urandom & 32'h3FF;
            if (jt[2:1] == 2'h3) jt[2:1] = 2'h2;
            apb(1'b1, CTT_JEITA_OFS, jt);
            rdchk("jeita_rb", CTT_JEITA_OFS, 32'h3FF, jt);
            for (int r = 0; r < 3; r++) begin
                ts <= TSV[r];
                tick(10);
                chk("derate", derate(jt, r), {cap, scale});
            end
        end
        apb(1'b1, CTT_JEITA_OFS, JT_RESET);
        ts <= 7'h00;
        tick(12);
        chk("hot_stop", 32'h0, chg);
        ts <= TSV[0];
        tick(12);
        chk("resume", 32'h1, chg);
        // Status flags under random regulation inputs
        repeat (4) begin
            {iin, vin, smin, treg} <= 4'($urandom);
            tick(10);
            rdchk("flags", CTT_STAT_OFS, 32'h38, {26'h0, iin, vin, smin, 3'h0});
        end
        // Termination held off by input regulation
        {iin, vin, smin, treg} <= 4'h8;
        rechg <= 1'b1;
        below <= 1'b1;
        n0 = irq_n;
        tick(40);
        chk("holdoff", n0, irq_n);
        iin <= 1'b0;
        tick(40);
        chk("term_irq", n0 + 1, irq_n);
        rdchk("phase", CTT_STAT_OFS, 32'h3, PH_DONE);
        // Termination disabled
        apb(1'b1, CTT_CTRL_OFS, CTL_RESET & ~32'h1);
        below <= 1'b0;
        restart();
        n0 = irq_n;
        below <= 1'b1;
        tick(40);
        chk("no_term", {n0, 1'b1}, {irq_n, chg});
        // Top-off of one unit, setting changed after detection
        apb(1'b1, CTT_CTRL_OFS, CTL_RESET | 32'h40);
        below <= 1'b0;
        restart();
        n0 = irq_n;
        below <= 1'b1;
        tick(40);
        chk("topoff_on", {n0 + 1, 1'b1}, {irq_n, chg});
        apb(1'b1, CTT_CTRL_OFS, CTL_RESET | 32'hC0);
        tick(3250);
        rdchk("topoff_run", CTT_STAT_OFS, 32'h4, 32'h4);
        tick(600);
        chk("topoff_end", {n0 + 2, 1'b0}, {irq_n, chg});
        rdchk("topoff_done", CTT_STAT_OFS, 32'h7, PH_DONE);
        // Boost window
        {below, rechg, low_ok, pin_n, boost} <= 5'h7;
        tick(40);
        rdchk("otg", CTT_STAT_OFS, 32'h380, {22'h0, BUS_OTG, 7'h0});
        ts <= TSV[0] | 7'h40;
        tick(40);
        rdchk("bus_off", CTT_STAT_OFS, 32'h380, 32'h0);
        rdchk("bcold", CTT_FAULT_OFS, 32'h1C, {27'h0, NTC_BCOLD, 2'h0});
        ts <= TSV[0];
        tick(40);
        chk("boost_back", 32'h1, bon);
        rdchk("ntc_clr", CTT_FAULT_OFS, 32'h1C, 32'h0);
        // Two hour limit after a restart
        {low_ok, boost} <= 2'h0;
        apb(1'b1, CTT_CTRL_OFS, CTL_RESET);
        restart();
        n0 = irq_n;
        tick(28000);
        chk("timer_run", 32'h1, chg);
        tick(1200);
        chk("timer_end", {n0 + 1, 1'b0}, {irq_n, chg});
        rdchk("tmr_fault", CTT_FAULT_OFS, 32'h3, FLT_TMR);
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> hdl/ctt_top.sv
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module ctt_top #(
    parameter int TICK_CYCLES = ctt_pkg::TICK_CYC,
    parameter int PULSE_CYCLES = ctt_pkg::PULSE_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Pins and analog comparators (asynchronous)
    input wire logic charge_enable_pin_n_i,
    input wire logic vbat_above_rechg_i,
    input wire logic ichg_below_term_i,
    input wire logic vbat_above_low_i,
    input wire logic iin_reg_i,
    input wire logic vin_reg_i,
    input wire logic therm_reg_i,
    input wire logic sys_min_reg_i,
    input wire logic boost_req_i,
    input wire logic [6:0] thermistor_sense_input_i,
    // Charger controls
    output logic charge_on_o,
    output logic boost_on_o,
    output logic [1:0] cur_scale_o,
    output logic volt_cap_4v1_o,
    output logic host_interrupt_n_o,
    output logic host_interrupt_n_oe_o
);
    import ctt_pkg::*;

    // Synchronisers: 16 asynchronous bits
    localparam int NS = 16;
    logic [NS-1:0] raw, s1_q, s2_q;
    assign raw = {thermistor_sense_input_i, boost_req_i, sys_min_reg_i, therm_reg_i, vin_reg_i,
                  iin_reg_i, vbat_above_low_i, ichg_below_term_i, vbat_above_rechg_i, charge_enable_pin_n_i};
    // Two stages; first stage read only by second
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s1_q <= '1;
            s2_q <= '1;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    logic cen_n, rechg, below_term, above_low, iin, vin, therm, sysmin, boost_req;
    logic [6:0] ts; // Comparator bits, 1 = voltage above threshold
    assign cen_n = s2_q[0];
    assign rechg = s2_q[1];
    assign below_term = s2_q[2];
    assign above_low = s2_q[3];
    assign iin = s2_q[4];
    assign vin = s2_q[5];
    assign therm = s2_q[6];
    assign sysmin = s2_q[7];
    assign boost_req = s2_q[8];
    assign ts = s2_q[15:9];

    // Registers
    logic [31:0] ctrl_q, jeita_q;
    logic reg_rst; // Register reset pulse
    logic apb_wr;
    assign apb_wr = psel_i && penable_i && pwrite_i;
    assign reg_rst = apb_wr && paddr_i == CTT_CTRL_OFS && pwdata_i[CTL_RST];
    // Writable configuration; reset bit self-clears
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || reg_rst) begin
            ctrl_q <= CTL_RESET;
            jeita_q <= JT_RESET;
        end else if (apb_wr && paddr_i == CTT_CTRL_OFS) begin
            ctrl_q <= pwdata_i & 32'h0000_07DF;
        end else if (apb_wr && paddr_i == CTT_JEITA_OFS) begin
            jeita_q <= pwdata_i & 32'h0000_03FF;
        end
    end

    // Temperature classification (RQ24): ts[0]=T1 cold .. ts[3]=T4 hot
    // T2/T3 alternatives picked by selects (RQ14)
    logic in_window, cool, warm, b_cold, b_hot;
    logic [1:0] vt2, vt3;
    assign vt2 = jeita_q[JT_VT2+:2];
    assign vt3 = jeita_q[JT_VT3+:2];
    assign in_window = !ts[0] && ts[3]; // RQ24
    // A nonzero select moves the boundary onto the alternate comparator
    assign cool = (vt2 == 2'h0) ? ts[1] : ts[4]; // RQ14
    assign warm = (vt3 == 2'h0) ? !ts[2] : !ts[5]; // RQ14
    assign b_cold = ts[6];
    assign b_hot = !ts[3];

    // Timebase and half rate (RQ23)
    logic [31:0] pre_q;
    logic tick, half_q, slow, cnt_en;
    assign tick = pre_q == 32'(TICK_CYCLES - 1);
    assign slow = ctrl_q[CTL_HALF] && (iin || vin || therm || cool); // RQ18
    assign cnt_en = tick && (!slow || half_q); // RQ23
    // Prescaler
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || tick)
            pre_q <= 32'h0000_0000;
        else
            pre_q <= pre_q + 32'h0000_0001;
    end
    // Alternate tick toggle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i)
            half_q <= 1'b0;
        else if (tick)
            half_q <= !half_q;
    end

    // Charge state machine
    ctt_state_type st_q;
    logic enabled, cen_n_q, cfg_q, restart, term_cond, safety_exp, topoff_exp;
    logic [17:0] safe_q, topoff_q, topoff_lim_q;
    logic [1:0] fault_q;
    logic int_req;
    assign enabled = ctrl_q[CTL_CFG] && !cen_n;
    assign restart = (cen_n_q && !cen_n) || (!cfg_q && ctrl_q[CTL_CFG]) || reg_rst; // RQ7 RQ19
    // RQ1 RQ3 RQ4
    assign term_cond = rechg && below_term && !iin && !vin && !therm && ctrl_q[CTL_TERM_EN];
    assign safety_exp = ctrl_q[CTL_TMR_EN] && safe_q >= (!above_low ? 18'(LIM_SHORT_S) :
                        ctrl_q[CTL_LONG] ? 18'(LIM_LONG_S) : 18'(LIM_MID_S)); // RQ17
    assign topoff_exp = topoff_q >= topoff_lim_q;
    // Edge history for enable pin and config bit
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cen_n_q <= 1'b1;
            cfg_q <= 1'b0;
        end else begin
            cen_n_q <= cen_n;
            cfg_q <= ctrl_q[CTL_CFG];
        end
    end
    // Phase transitions
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            fault_q <= 2'h0;
        end else if (!enabled || restart) begin
            st_q <= ST_IDLE; // RQ19
            fault_q <= 2'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (in_window && fault_q == 2'h0)
                        st_q <= ST_CHG; // RQ11
                end
                ST_CHG, ST_TOPOFF: begin
                    if (safety_exp) begin
                        st_q <= ST_DONE; // RQ16
                        fault_q <= FLT_TMR;
                    end else if (!in_window)
                        st_q <= ST_SUSP; // RQ11
                    else if (st_q == ST_CHG && term_cond)
                        st_q <= (ctrl_q[CTL_TOPOFF+:2] != 2'h0) ? ST_TOPOFF : ST_DONE; // RQ5
                    else if (st_q == ST_TOPOFF && topoff_exp)
                        st_q <= ST_DONE; // RQ5
                end
                ST_SUSP: begin
                    if (in_window)
                        st_q <= ST_CHG; // RQ11
                end
                ST_DONE: begin
                    if (!rechg && fault_q == 2'h0)
                        st_q <= ST_CHG;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // Safety timer: pauses in suspend, resets on restart (RQ19)
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || restart || st_q == ST_IDLE)
            safe_q <= 18'h00000;
        else if (cnt_en && (st_q == ST_CHG || st_q == ST_TOPOFF))
            safe_q <= safe_q + 18'h00001;
    end
    // Top-off: setting latched at detection, same gating (RQ5 RQ7 RQ8)
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || restart || (st_q == ST_CHG && term_cond)) begin
            topoff_q <= 18'h00000; // RQ7
            topoff_lim_q <= 18'(TOPOFF_UNIT_S) * {16'h0000, ctrl_q[CTL_TOPOFF+:2]}; // RQ8
        end else if (cnt_en && st_q == ST_TOPOFF)
            topoff_q <= topoff_q + 18'h00001; // RQ5
    end
    // Interrupt events: termination, top-off start/end, safety expiry
    assign int_req = (st_q != ST_DONE && st_q != ST_IDLE && !(!enabled || restart)
                      && (safety_exp || (st_q == ST_CHG && term_cond) || (st_q == ST_TOPOFF && topoff_exp))
                      && (st_q != ST_SUSP)); // RQ2 RQ9 RQ16

    // Interrupt pulse generator (RQ22)
    logic [15:0] ip_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i)
            ip_q <= 16'h0000;
        else if (int_req)
            ip_q <= 16'(PULSE_CYCLES);
        else if (ip_q != 16'h0000)
            ip_q <= ip_q - 16'h0001;
    end
    // Open drain: enable high pulls output low
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            host_interrupt_n_o <= 1'b1;
            host_interrupt_n_oe_o <= 1'b0;
        end else begin
            host_interrupt_n_o <= !(int_req || ip_q > 16'h0001); // RQ22
            host_interrupt_n_oe_o <= int_req || ip_q > 16'h0001;
        end
    end

    // Derating and power outputs, charge only while charging (RQ10)
    logic charging;
    assign charging = st_q == ST_CHG || st_q == ST_TOPOFF;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            charge_on_o <= 1'b0;
            cur_scale_o <= 2'h3;
            volt_cap_4v1_o <= 1'b0;
            boost_on_o <= 1'b0;
        end else begin
            charge_on_o <= charging; // RQ10 RQ11
            volt_cap_4v1_o <= 1'b0;
            cur_scale_o <= 2'h3; // 3 = full current
            if (charging && warm) begin
                volt_cap_4v1_o <= !jeita_q[JT_VSET_H]; // RQ12
                cur_scale_o <= jeita_q[JT_ISET_H+:2] == 2'h3 ? 2'h3 : jeita_q[JT_ISET_H+:2]; // RQ12
            end else if (charging && cool) begin
                volt_cap_4v1_o <= jeita_q[JT_VSET_L]; // RQ13
                cur_scale_o <= !jeita_q[JT_ISET_LEN] ? 2'h0 : jeita_q[JT_ISET_L] ? 2'h1 : 2'h2; // RQ13
            end
            boost_on_o <= boost_req && !charging && !b_cold && !b_hot; // RQ15
        end
    end

    // APB read path, zero-wait
    logic [31:0] rd;
    logic [1:0] phase;
    logic [2:0] ntc, bus;
    assign phase = st_q == ST_DONE && fault_q == 2'h0 ? PH_DONE :
                   charging ? (above_low ? PH_FAST : PH_PRE) : PH_OFF; // RQ2
    assign ntc = !boost_req || charging ? NTC_NORMAL : b_cold ? NTC_BCOLD : b_hot ? NTC_BHOT : NTC_NORMAL; // RQ15
    assign bus = boost_req && !charging && ntc == NTC_NORMAL ? BUS_OTG : BUS_NONE; // RQ15
    always_comb begin
        case (paddr_i)
            CTT_CTRL_OFS: rd = ctrl_q;
            CTT_JEITA_OFS: rd = jeita_q;
            // RQ6 RQ20 RQ21
            CTT_STAT_OFS: rd = {22'h0, bus, 1'b0, iin, vin, sysmin, st_q == ST_TOPOFF, phase};
            CTT_FAULT_OFS: rd = {27'h0, ntc, fault_q}; // RQ16
            default: rd = 32'h0000_0000;
        endcase
    end
    // Registered answer
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && paddr_i > CTT_FAULT_OFS;
            prdata_o <= rd;
        end
    end
endmodule
`default_nettype wire

// >>> include/ctt_pkg.sv
// Operation
// (RQ1) Terminate when above recharge and below termination current
// (RQ2) Termination sets phase 11 and pulses interrupt
// (RQ3) Input or thermal regulation holds off termination
// (RQ4) Termination enable low blocks termination
// (RQ5) Top-off keeps CV, follows safety timer rate
// (RQ6) Status bit shows top-off timer running
// (RQ7) Top-off cleared by enable, termination, register reset
// (RQ8) Top-off setting latched at termination detection
// (RQ9) Interrupt pulse at top-off start and end
// (RQ10) Temperature qualification only while charging
// (RQ11) Start inside window, suspend when outside
// (RQ12) Warm range voltage and current derating
// (RQ13) Cool range current enable, select, voltage
// (RQ14) Cool and warm thresholds selected independently
// (RQ15) Boost suspends outside window, reports thermistor fault
// (RQ16) Safety expiry stops charge, fault 11, pulse
// (RQ17) Limit 2h low battery, 16h or 7h
// (RQ18) Half rate under regulation or cool
// (RQ19) Timer pauses on fault, resets on restart
// (RQ20) Minimum system field and regulation flag
// (RQ21) Input current and voltage limit flags
// (RQ22) Interrupt pulse low for 256 microseconds
// (RQ23) One prescaled timebase, alternate-tick half rate
// (RQ24) Lower thermistor voltage means hotter range
package ctt_pkg;
    // APB register byte offsets
    localparam logic [7:0] CTT_CTRL_OFS = 8'h00;
    localparam logic [7:0] CTT_JEITA_OFS = 8'h04;
    localparam logic [7:0] CTT_STAT_OFS = 8'h08;
    localparam logic [7:0] CTT_FAULT_OFS = 8'h0C;
    // Control register fields
    localparam int CTL_TERM_EN = 0;
    localparam int CTL_TMR_EN = 1;
    localparam int CTL_LONG = 2;
    localparam int CTL_HALF = 3;
    localparam int CTL_CFG = 4;
    localparam int CTL_RST = 5;
    localparam int CTL_TOPOFF = 6;
    localparam int CTL_SYSMIN = 8;
    localparam logic [31:0] CTL_RESET = 32'h0000_051F;
    // Jeita register fields
    localparam int JT_VSET_H = 0;
    localparam int JT_ISET_H = 1;
    localparam int JT_ISET_L = 3;
    localparam int JT_ISET_LEN = 4;
    localparam int JT_VSET_L = 5;
    localparam int JT_VT2 = 6;
    localparam int JT_VT3 = 8;
    localparam logic [31:0] JT_RESET = 32'h0000_0150;
    // Timing: 256 us pulse at 40 MHz
    localparam int CLK_MHZ = 40;
    localparam int PULSE_US = 256;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    // Timebase tick of one second
    localparam int TICK_S = 1;
    localparam int TICK_CYC = TICK_S * CLK_MHZ * 1000000;
    // Limits and top-off unit in seconds
    localparam int LIM_SHORT_S = 2 * 3600;
    localparam int LIM_LONG_S = 16 * 3600;
    localparam int LIM_MID_S = 7 * 3600;
    localparam int TOPOFF_UNIT_S = 15 * 60;
    // Phase, fault, thermistor and bus codes
    localparam logic [1:0] PH_OFF = 2'h0;
    localparam logic [1:0] PH_PRE = 2'h1;
    localparam logic [1:0] PH_FAST = 2'h2;
    localparam logic [1:0] PH_DONE = 2'h3;
    localparam logic [1:0] FLT_TMR = 2'h3;
    localparam logic [2:0] NTC_NORMAL = 3'h0;
    localparam logic [2:0] NTC_BCOLD = 3'h5;
    localparam logic [2:0] NTC_BHOT = 3'h6;
    localparam logic [2:0] BUS_OTG = 3'h7;
    localparam logic [2:0] BUS_NONE = 3'h0;
    // Charge states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CHG = 5'b00010,
        ST_TOPOFF = 5'b00100,
        ST_DONE = 5'b01000,
        ST_SUSP = 5'b10000
    } ctt_state_type;
endpackage
